// [design/sco_pkg.sv]
// Constants and types shared by the supply control output pin logic.
package sco_pkg;

  // ---------------------------------------------------------------
  // Sizes.
  // ---------------------------------------------------------------
  localparam int unsigned SCO_NEN  = 12;
  localparam int unsigned SCO_NPWM = 8;
  localparam int unsigned SCO_NFLT = 3;
  localparam int unsigned SCO_AW   = 8;

  // ---------------------------------------------------------------
  // Register offsets.
  // ---------------------------------------------------------------
  localparam logic [7:0] SCO_OFF_EN_POL    = 8'h00;
  localparam logic [7:0] SCO_OFF_EN_DRV    = 8'h04;
  localparam logic [7:0] SCO_OFF_EN_MODE   = 8'h08;
  localparam logic [7:0] SCO_OFF_EN_REQ    = 8'h0c;
  localparam logic [7:0] SCO_OFF_EN_GPO    = 8'h10;
  localparam logic [7:0] SCO_OFF_PWM_CTL   = 8'h14;
  localparam logic [7:0] SCO_OFF_DUTY0     = 8'h18;
  localparam logic [7:0] SCO_OFF_DUTY7     = 8'h34;
  localparam logic [7:0] SCO_OFF_FLT_DRV0  = 8'h38;
  localparam logic [7:0] SCO_OFF_FLT_DRV2  = 8'h40;
  localparam logic [7:0] SCO_OFF_FLT_SHUT0 = 8'h44;
  localparam logic [7:0] SCO_OFF_FLT_SHUT2 = 8'h4c;
  localparam logic [7:0] SCO_OFF_STATUS    = 8'h50;
  localparam logic [7:0] SCO_OFF_IRQ_STAT  = 8'h54;
  localparam logic [7:0] SCO_OFF_IRQ_MASK  = 8'h58;

  // ---------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------
  localparam int unsigned SCO_PWM_GPO_LSB   = 8;
  localparam int unsigned SCO_PWM_LVL_LSB   = 16;
  localparam int unsigned SCO_ST_LINE_LSB   = 0;
  localparam int unsigned SCO_ST_PHASE_LSB  = 4;
  localparam int unsigned SCO_ST_SHUT_LSB   = 16;
  localparam int unsigned SCO_IRQ_MON_BIT   = 3;

  // ---------------------------------------------------------------
  // Reset values and timing.
  // ---------------------------------------------------------------
  localparam logic [11:0] SCO_RST_EN_POL  = 12'hfff;
  localparam logic [11:0] SCO_RST_EN_DRV  = 12'h000;
  localparam logic [11:0] SCO_RST_EN_MODE = 12'h000;
  localparam logic [3:0]  SCO_RST_IRQ_MSK = 4'h0;
  localparam logic [2:0]  SCO_RST_LINE    = 3'h7;
  localparam logic [7:0]  SCO_PWM_FULL    = 8'hff;
  localparam logic [7:0]  SCO_PWM_LAST    = 8'hfe;
  localparam logic [1:0]  SCO_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  SCO_RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Types.
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SCO_PH_RECALL, SCO_PH_HOLD, SCO_PH_MON} sco_phase_e;

  typedef struct packed {
    logic       en;
    logic       gpo;
    logic       lvl;
    logic [7:0] duty;
  } sco_pwm_cfg_s;

  typedef struct packed {
    logic o;
    logic oe;
  } sco_pin_s;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] val;
  } sco_sync_s;

endpackage

// [design/sco_sync3.sv]
// Three-stage pin synchroniser for the shared fault lines.
`timescale 1ns/10ps
`default_nettype none
module sco_sync3 (
  input  wire logic                         core_clk_i,
  input  wire logic                         rst_i,
  input  wire logic [sco_pkg::SCO_NFLT-1:0] pin_i,
  output logic      [sco_pkg::SCO_NFLT-1:0] val_o
);
  import sco_pkg::*;

  sco_sync_s q;
  sco_sync_s d;

  // ---------------------------------------------------------------
  // A change counts once the second and third stages agree.
  // ---------------------------------------------------------------
  always_comb begin
    d    = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int k = 0; k < SCO_NFLT; k++) begin
      if (q.s2[k] == q.s3[k]) begin
        d.val[k] = q.s3[k];
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '{s1: SCO_RST_LINE, s2: SCO_RST_LINE, s3: SCO_RST_LINE, val: SCO_RST_LINE};
    end else begin
      q <= d;
    end
  end

  assign val_o = q.val;

endmodule
`default_nettype wire

// [design/sco_pwm_chan.sv]
// One margin PWM output channel with general output reuse.
`timescale 1ns/10ps
`default_nettype none
module sco_pwm_chan (
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  input  wire logic [7:0]            cnt_i,
  input  wire sco_pkg::sco_pwm_cfg_s cfg_i,
  output var sco_pkg::sco_pin_s      pin_o
);
  import sco_pkg::*;

  sco_pin_s q;
  sco_pin_s d;

  // ---------------------------------------------------------------
  // Output drive.
  // ---------------------------------------------------------------
  always_comb begin
    d.oe = cfg_i.en | cfg_i.gpo;
    if (cfg_i.gpo) begin
      d.o = cfg_i.lvl;
    end else begin
      d.o = cfg_i.en & ((cfg_i.duty == SCO_PWM_FULL) | (cnt_i < cfg_i.duty));
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '{o: 1'b0, oe: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign pin_o = q;

  // ---------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  property p_pwm_hiz;
    (!cfg_i.en && !cfg_i.gpo) |=> !q.oe;
  endproperty
  a_pwm_hiz: assert property (p_pwm_hiz) else $error("Disabled margin output is driven.");

  property p_pwm_full;
    (cfg_i.en && !cfg_i.gpo && cfg_i.duty == SCO_PWM_FULL) [*2] |=> (q.o && q.oe);
  endproperty
  a_pwm_full: assert property (p_pwm_full) else $error("Full duty output went low.");

  property p_pwm_gpo;
    cfg_i.gpo |=> (q.oe && q.o == $past(cfg_i.lvl));
  endproperty
  a_pwm_gpo: assert property (p_pwm_gpo) else $error("General output level wrong.");

  c_pwm_pulse: cover property (cfg_i.en && !cfg_i.gpo ##1 q.o ##1 !q.o);

endmodule
`default_nettype wire

// [design/sco_out_ctrl.sv]
// Top of the supply control output pins with its AXI4-Lite register slave.
`timescale 1ns/10ps
`default_nettype none
module sco_out_ctrl (
  input  wire logic                         core_clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         s_axi_awvalid_i,
  output logic                              s_axi_awready_o,
  input  wire logic [sco_pkg::SCO_AW-1:0]   s_axi_awaddr_i,
  input  wire logic                         s_axi_wvalid_i,
  output logic                              s_axi_wready_o,
  input  wire logic [31:0]                  s_axi_wdata_i,
  input  wire logic [3:0]                   s_axi_wstrb_i,
  output logic                              s_axi_bvalid_o,
  input  wire logic                         s_axi_bready_i,
  output logic      [1:0]                   s_axi_bresp_o,
  input  wire logic                         s_axi_arvalid_i,
  output logic                              s_axi_arready_o,
  input  wire logic [sco_pkg::SCO_AW-1:0]   s_axi_araddr_i,
  output logic                              s_axi_rvalid_o,
  input  wire logic                         s_axi_rready_i,
  output logic      [31:0]                  s_axi_rdata_o,
  output logic      [1:0]                   s_axi_rresp_o,
  input  wire logic                         recall_done_i,
  input  wire logic                         monitor_run_i,
  input  wire logic [sco_pkg::SCO_NEN-1:0]  chan_fault_i,
  output logic      [sco_pkg::SCO_NEN-1:0]  chan_shutdown_o,
  input  wire logic [sco_pkg::SCO_NFLT-1:0] shared_fault_line_n_i,
  output logic      [sco_pkg::SCO_NFLT-1:0] shared_fault_line_n_o,
  output logic      [sco_pkg::SCO_NFLT-1:0] shared_fault_line_n_oe_o,
  output logic      [sco_pkg::SCO_NEN-1:0]  supply_enable_out_o,
  output logic      [sco_pkg::SCO_NEN-1:0]  supply_enable_out_oe_o,
  output logic      [sco_pkg::SCO_NPWM-1:0] margin_pwm_o,
  output logic      [sco_pkg::SCO_NPWM-1:0] margin_pwm_oe_o,
  output logic                              irq_o
);
  import sco_pkg::*;

  typedef struct packed {
    sco_phase_e                  ph;
    logic [SCO_NEN-1:0]          en_pol;
    logic [SCO_NEN-1:0]          en_drv;
    logic [SCO_NEN-1:0]          en_mode;
    logic [SCO_NEN-1:0]          en_req;
    logic [SCO_NEN-1:0]          en_gpo;
    logic [SCO_NPWM-1:0]         pwm_en;
    logic [SCO_NPWM-1:0]         pwm_gpo;
    logic [SCO_NPWM-1:0]         pwm_lvl;
    logic [7:0]                  pwm_cnt;
    logic [SCO_NPWM-1:0][7:0]    duty;
    logic [SCO_NFLT-1:0][11:0]   flt_drv;
    logic [SCO_NFLT-1:0][11:0]   flt_shut;
    logic [3:0]                  irq_stat;
    logic [3:0]                  irq_mask;
    logic [SCO_NFLT-1:0]         low_prev;
    logic [SCO_NFLT-1:0]         flt_oe;
    logic [SCO_NEN-1:0]          en_o;
    logic [SCO_NEN-1:0]          en_oe;
    logic [SCO_NEN-1:0]          shut;
    logic                        irq;
    logic                        aw_held;
    logic                        w_held;
    logic                        awready;
    logic                        wready;
    logic                        bvalid;
    logic                        arready;
    logic                        rvalid;
    logic [7:0]                  awaddr;
    logic [31:0]                 wdata;
    logic [3:0]                  wstrb;
    logic [31:0]                 rdata;
    logic [1:0]                  bresp;
    logic [1:0]                  rresp;
  } sco_top_s;

  localparam sco_top_s SCO_TOP_RST = '{ph: SCO_PH_RECALL, en_pol: SCO_RST_EN_POL, en_drv: SCO_RST_EN_DRV,
                                       en_mode: SCO_RST_EN_MODE, irq_mask: SCO_RST_IRQ_MSK, default: '0};

  sco_top_s            q;
  sco_top_s            n;
  logic [SCO_NFLT-1:0] line_val;
  sco_pwm_cfg_s        pcfg [SCO_NPWM];
  sco_pin_s            ppin [SCO_NPWM];

  // ---------------------------------------------------------------
  // Register read decode and byte lane merge.
  // ---------------------------------------------------------------
  function automatic logic [32:0] sco_rd(input sco_top_s s, input logic [7:0] a);
    logic [31:0] v;
    logic        hit;
    v   = '0;
    hit = 1'b1;
    if (a == SCO_OFF_EN_POL) begin
      v[SCO_NEN-1:0] = s.en_pol;
    end else if (a == SCO_OFF_EN_DRV) begin
      v[SCO_NEN-1:0] = s.en_drv;
    end else if (a == SCO_OFF_EN_MODE) begin
      v[SCO_NEN-1:0] = s.en_mode;
    end else if (a == SCO_OFF_EN_REQ) begin
      v[SCO_NEN-1:0] = s.en_req;
    end else if (a == SCO_OFF_EN_GPO) begin
      v[SCO_NEN-1:0] = s.en_gpo;
    end else if (a == SCO_OFF_PWM_CTL) begin
      v[SCO_NPWM-1:0]                     = s.pwm_en;
      v[SCO_PWM_GPO_LSB +: SCO_NPWM]      = s.pwm_gpo;
      v[SCO_PWM_LVL_LSB +: SCO_NPWM]      = s.pwm_lvl;
    end else if (a >= SCO_OFF_DUTY0 && a <= SCO_OFF_DUTY7) begin
      v[7:0] = s.duty[3'((a - SCO_OFF_DUTY0) >> 2)];
    end else if (a >= SCO_OFF_FLT_DRV0 && a <= SCO_OFF_FLT_DRV2) begin
      v[11:0] = s.flt_drv[2'((a - SCO_OFF_FLT_DRV0) >> 2)];
    end else if (a >= SCO_OFF_FLT_SHUT0 && a <= SCO_OFF_FLT_SHUT2) begin
      v[11:0] = s.flt_shut[2'((a - SCO_OFF_FLT_SHUT0) >> 2)];
    end else if (a == SCO_OFF_STATUS) begin
      v[SCO_ST_LINE_LSB +: SCO_NFLT] = ~s.low_prev;
      v[SCO_ST_PHASE_LSB +: 2]       = s.ph;
      v[SCO_ST_SHUT_LSB +: SCO_NEN]  = s.shut;
    end else if (a == SCO_OFF_IRQ_STAT) begin
      v[3:0] = s.irq_stat;
    end else if (a == SCO_OFF_IRQ_MASK) begin
      v[3:0] = s.irq_mask;
    end else begin
      hit = 1'b0;
    end
    return {hit, v};
  endfunction

  function automatic logic [31:0] sco_merge(input logic [31:0] o, input logic [31:0] w, input logic [3:0] b);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) begin
        r[8*i +: 8] = w[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Fault line sense.
  // ---------------------------------------------------------------
  sco_sync3 u_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .pin_i      (shared_fault_line_n_i),
    .val_o      (line_val)
  );

  // ---------------------------------------------------------------
  // Next state.
  // ---------------------------------------------------------------
  always_comb begin
    logic [32:0]         rd;
    logic [31:0]         wm;
    logic [3:0]          clr;
    logic [3:0]          ev;
    logic [SCO_NFLT-1:0] lo;
    logic [SCO_NEN-1:0]  act;
    logic [SCO_NEN-1:0]  lvl;
    n   = q;
    rd  = '0;
    wm  = '0;
    clr = '0;
    lo  = ~line_val;
    ev  = '0;
    act = (q.en_mode & q.en_gpo) | (~q.en_mode & q.en_req & ~q.shut);
    lvl = ~(act ^ q.en_pol);
    case (q.ph)
      SCO_PH_RECALL: if (recall_done_i) begin
        n.ph = SCO_PH_HOLD;
      end
      SCO_PH_HOLD: if (monitor_run_i) begin
        n.ph = SCO_PH_MON;
      end
      SCO_PH_MON: n.ph = SCO_PH_MON;
      default: n.ph = SCO_PH_RECALL;
    endcase
    n.shut = '0;
    if (q.ph == SCO_PH_MON) begin
      for (int k = 0; k < SCO_NFLT; k++) begin
        n.shut = n.shut | (q.flt_shut[k] & {SCO_NEN{lo[k]}});
      end
    end
    n.flt_oe = '0;
    if (n.ph == SCO_PH_HOLD) begin
      n.flt_oe = '1;
    end else if (n.ph == SCO_PH_MON) begin
      for (int k = 0; k < SCO_NFLT; k++) begin
        n.flt_oe[k] = |(q.flt_drv[k] & chan_fault_i);
      end
    end
    n.en_o  = lvl & q.en_drv;
    n.en_oe = q.en_drv | ~lvl;
    if (n.ph == SCO_PH_RECALL) begin
      n.en_o  = '0;
      n.en_oe = '0;
    end
    n.pwm_cnt = (q.pwm_cnt == SCO_PWM_LAST) ? 8'h00 : 8'(q.pwm_cnt + 8'h01);
    if (s_axi_awvalid_i && q.awready) begin
      n.aw_held = 1'b1;
      n.awaddr  = {s_axi_awaddr_i[7:2], 2'b00};
    end
    if (s_axi_wvalid_i && q.wready) begin
      n.w_held = 1'b1;
      n.wdata  = s_axi_wdata_i;
      n.wstrb  = s_axi_wstrb_i;
    end
    if (q.bvalid && s_axi_bready_i) begin
      n.bvalid = 1'b0;
    end
    if (q.aw_held && q.w_held && !q.bvalid) begin
      rd        = sco_rd(q, q.awaddr);
      wm        = sco_merge(rd[31:0], q.wdata, q.wstrb);
      n.aw_held = 1'b0;
      n.w_held  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = rd[32] ? SCO_RESP_OKAY : SCO_RESP_SLVERR;
      if (q.awaddr == SCO_OFF_EN_POL) begin
        n.en_pol = wm[SCO_NEN-1:0];
      end else if (q.awaddr == SCO_OFF_EN_DRV) begin
        n.en_drv = wm[SCO_NEN-1:0];
      end else if (q.awaddr == SCO_OFF_EN_MODE) begin
        n.en_mode = wm[SCO_NEN-1:0];
      end else if (q.awaddr == SCO_OFF_EN_REQ) begin
        n.en_req = wm[SCO_NEN-1:0];
      end else if (q.awaddr == SCO_OFF_EN_GPO) begin
        n.en_gpo = wm[SCO_NEN-1:0];
      end else if (q.awaddr == SCO_OFF_PWM_CTL) begin
        n.pwm_en  = wm[SCO_NPWM-1:0];
        n.pwm_gpo = wm[SCO_PWM_GPO_LSB +: SCO_NPWM];
        n.pwm_lvl = wm[SCO_PWM_LVL_LSB +: SCO_NPWM];
      end else if (q.awaddr >= SCO_OFF_DUTY0 && q.awaddr <= SCO_OFF_DUTY7) begin
        n.duty[3'((q.awaddr - SCO_OFF_DUTY0) >> 2)] = wm[7:0];
      end else if (q.awaddr >= SCO_OFF_FLT_DRV0 && q.awaddr <= SCO_OFF_FLT_DRV2) begin
        n.flt_drv[2'((q.awaddr - SCO_OFF_FLT_DRV0) >> 2)] = wm[11:0];
      end else if (q.awaddr >= SCO_OFF_FLT_SHUT0 && q.awaddr <= SCO_OFF_FLT_SHUT2) begin
        n.flt_shut[2'((q.awaddr - SCO_OFF_FLT_SHUT0) >> 2)] = wm[11:0];
      end else if (q.awaddr == SCO_OFF_IRQ_STAT) begin
        clr = q.wdata[3:0] & {4{q.wstrb[0]}};
      end else if (q.awaddr == SCO_OFF_IRQ_MASK) begin
        n.irq_mask = wm[3:0];
      end
    end
    n.awready = !n.aw_held && !n.bvalid;
    n.wready  = !n.w_held && !n.bvalid;
    if (q.rvalid && s_axi_rready_i) begin
      n.rvalid = 1'b0;
    end
    if (q.arready && s_axi_arvalid_i) begin
      rd       = sco_rd(q, {s_axi_araddr_i[7:2], 2'b00});
      n.rvalid = 1'b1;
      n.rdata  = rd[31:0];
      n.rresp  = rd[32] ? SCO_RESP_OKAY : SCO_RESP_SLVERR;
    end
    n.arready = !n.rvalid;
    ev[SCO_NFLT-1:0]    = lo & ~q.low_prev & {SCO_NFLT{q.ph == SCO_PH_MON}};
    ev[SCO_IRQ_MON_BIT] = (n.ph == SCO_PH_MON) && (q.ph != SCO_PH_MON);
    n.low_prev          = lo;
    n.irq_stat          = (q.irq_stat & ~clr) | ev;
    n.irq               = |(n.irq_stat & n.irq_mask);
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= SCO_TOP_RST;
    end else begin
      q <= n;
    end
  end

  // ---------------------------------------------------------------
  // Margin PWM channels.
  // ---------------------------------------------------------------
  for (genvar g = 0; g < SCO_NPWM; g++) begin : g_pwm
    assign pcfg[g] = '{en: q.pwm_en[g] && q.ph != SCO_PH_RECALL, gpo: q.pwm_gpo[g] && q.ph != SCO_PH_RECALL,
                       lvl: q.pwm_lvl[g], duty: q.duty[g]};
    sco_pwm_chan u_pwm (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .cnt_i      (q.pwm_cnt),
      .cfg_i      (pcfg[g]),
      .pin_o      (ppin[g])
    );
    assign margin_pwm_o[g]    = ppin[g].o;
    assign margin_pwm_oe_o[g] = ppin[g].oe;
  end

  // ---------------------------------------------------------------
  // Outputs.
  // ---------------------------------------------------------------
  assign s_axi_awready_o          = q.awready;
  assign s_axi_wready_o           = q.wready;
  assign s_axi_bvalid_o           = q.bvalid;
  assign s_axi_bresp_o            = q.bresp;
  assign s_axi_arready_o          = q.arready;
  assign s_axi_rvalid_o           = q.rvalid;
  assign s_axi_rdata_o            = q.rdata;
  assign s_axi_rresp_o            = q.rresp;
  assign chan_shutdown_o          = q.shut;
  assign shared_fault_line_n_o    = '0;
  assign shared_fault_line_n_oe_o = q.flt_oe;
  assign supply_enable_out_o      = q.en_o;
  assign supply_enable_out_oe_o   = q.en_oe;
  assign irq_o                    = q.irq;

  // ---------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  property p_recall_hiz;
    (q.ph == SCO_PH_RECALL) |-> (q.en_oe == '0 && q.flt_oe == '0);
  endproperty
  a_recall_hiz: assert property (p_recall_hiz) else $error("Pin driven before recall done.");
  property p_pol;
    (n.ph != SCO_PH_RECALL) |=> (((q.en_o ^ ~$past(q.en_pol))
                                 & $past(q.en_drv & ~q.en_mode & ~(q.en_req & ~q.shut))) == '0);
  endproperty
  a_pol: assert property (p_pol) else $error("Push-pull idle enable level wrong.");
  property p_od;
    (n.ph != SCO_PH_RECALL) |=> ((q.en_o & ~$past(q.en_drv)) == '0);
  endproperty
  a_od: assert property (p_od) else $error("Open-drain enable drove high.");
  property p_gpo;
    (n.ph != SCO_PH_RECALL && q.en_mode[0] && q.en_drv[0]) |=> (q.en_oe[0] && q.en_o[0] == $past(q.en_gpo[0] ~^ q.en_pol[0]));
  endproperty
  a_gpo: assert property (p_gpo) else $error("General output 0 level wrong.");
  property p_map;
    (n.ph == SCO_PH_MON) |=> (q.flt_oe[1] == $past(|(q.flt_drv[1] & chan_fault_i)));
  endproperty
  a_map: assert property (p_map) else $error("Fault line 1 drive wrong.");
  property p_shut;
    (q.ph == SCO_PH_MON && !line_val[0]) |=> ((q.shut & $past(q.flt_shut[0])) == $past(q.flt_shut[0]));
  endproperty
  a_shut: assert property (p_shut) else $error("Channel not shut down on fault line.");
  property p_rst_rel;
    disable iff (1'b0) rst_i |-> (shared_fault_line_n_oe_o == '0);
  endproperty
  a_rst_rel: assert property (p_rst_rel) else $error("Fault line driven during reset.");
  property p_hold;
    (q.ph == SCO_PH_RECALL && recall_done_i && !monitor_run_i) |=> (q.flt_oe == '1) [*1] ##0 (q.ph == SCO_PH_HOLD);
  endproperty
  a_hold: assert property (p_hold) else $error("Fault lines not pulled low after recall.");
  property p_release;
    (n.ph == SCO_PH_MON && chan_fault_i == '0) |=> (q.flt_oe == '0);
  endproperty
  a_release: assert property (p_release) else $error("Fault line held without fault.");
  c_mon:  cover property (q.ph == SCO_PH_HOLD ##1 q.ph == SCO_PH_MON);
  c_shut: cover property (q.shut != '0);
  c_irq:  cover property (q.irq);
endmodule
`default_nettype wire

// [verif/sco_peer_model.sv]
// Peer device and pull-ups on the three shared fault lines.
`timescale 1ns/10ps
`default_nettype none
module sco_peer_model (
  input  wire logic [2:0] dut_oe_i,
  input  wire logic [2:0] peer_pull_i,
  output logic      [2:0] line_n_o
);
  // Wired line with pull-up: any party pulling low wins.
  assign line_n_o = ~(dut_oe_i | peer_pull_i);
endmodule
`default_nettype wire

// [verif/sco_out_ctrl_tb_top.sv]
// Self-checking bench for the supply control output pins.
`timescale 1ns/10ps
`default_nettype none
module sco_out_ctrl_tb_top;
  import sco_pkg::*;
  logic        clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, rcd = 0, mon = 0;
  logic [7:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0, rdd;
  logic [11:0] cf = 0, sd, so, soe;
  logic [2:0]  pp = 0, foe, fo, fln;
  logic [7:0]  po, poe;
  logic [1:0]  br, rr;
  logic        awr, wrd, bv, arr, rv, irq;
  int          fails = 0, n_tests = 0;
  always #20 clk = ~clk;
  sco_out_ctrl dut (.core_clk_i(clk), .rst_i(rst), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre), .s_axi_bresp_o(br),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rre), .s_axi_rdata_o(rdd), .s_axi_rresp_o(rr), .recall_done_i(rcd),
    .monitor_run_i(mon), .chan_fault_i(cf), .chan_shutdown_o(sd), .shared_fault_line_n_i(fln),
    .shared_fault_line_n_o(fo), .shared_fault_line_n_oe_o(foe), .supply_enable_out_o(so),
    .supply_enable_out_oe_o(soe), .margin_pwm_o(po), .margin_pwm_oe_o(poe), .irq_o(irq));
  sco_peer_model peer (.dut_oe_i(foe), .peer_pull_i(pp), .line_n_o(fln));
  task automatic ck(input logic [31:0] s, e, input string n);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int i;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bre <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
      if (bv) break;
    end
    bre <= 0;
    if (i == 50) begin
      fails++;
      test_done;
    end
    ck(br, e, "bresp");
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int i;
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rre <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arr) arv <= 0;
      if (rv) break;
    end
    rre <= 0;
    if (i == 50) begin
      fails++;
      test_done;
    end
    d = rdd;
    ck(rr, SCO_RESP_OKAY, "rresp");
  endtask
  task automatic t_reset;
    logic [31:0] d;
    repeat (2) @(posedge clk);
    ck({soe, poe, foe}, 32'h0, "oe in reset");
    repeat (2) @(posedge clk);
    rst <= 0;
    repeat (4) @(posedge clk);
    ck({soe, poe, foe}, 32'h0, "oe in recall");
    rd(SCO_OFF_EN_POL, d);
    ck(d[11:0], SCO_RST_EN_POL, "pol reset");
    wr(8'h5c, 32'h0, SCO_RESP_SLVERR);
  endtask
  task automatic t_phase;
    rcd <= 1;
    repeat (3) @(posedge clk);
    ck(foe, 3'h7, "hold pull");
    ck(fln, 3'h0, "line level");
    ck(fo, 3'h0, "line drive level");
    mon <= 1;
    repeat (3) @(posedge clk);
    ck(foe, 3'h0, "mon release");
  endtask
  task automatic t_flt;
    wr(SCO_OFF_FLT_DRV0, 32'h0000_0004, SCO_RESP_OKAY);
    wr(SCO_OFF_FLT_DRV2, 32'h0000_0004, SCO_RESP_OKAY);
    cf <= 12'h004;
    repeat (3) @(posedge clk);
    ck(foe, 3'h5, "fault subset");
    cf <= 12'h000;
    repeat (3) @(posedge clk);
    ck(foe, 3'h0, "fault gone");
  endtask
  task automatic t_shut;
    wr(SCO_OFF_FLT_SHUT0 + 8'h04, 32'h0000_00f0, SCO_RESP_OKAY);
    wr(SCO_OFF_IRQ_MASK, 32'h0000_0002, SCO_RESP_OKAY);
    pp <= 3'h2;
    repeat (8) @(posedge clk);
    ck(sd, 12'h0f0, "peer shutdown");
    ck(irq, 1'b1, "irq set");
    pp <= 3'h0;
    repeat (8) @(posedge clk);
    ck(sd, 12'h000, "shutdown ends");
    wr(SCO_OFF_IRQ_STAT, 32'h0000_0002, SCO_RESP_OKAY);
    repeat (2) @(posedge clk);
    ck(irq, 1'b0, "irq clear");
  endtask
  task automatic t_psen;
    logic [11:0] pol = 12'hf0f, drv = 12'h0ff, g = 12'h5a3, rq = 12'h00f, lv;
    wr(SCO_OFF_EN_POL, {20'h0, pol}, SCO_RESP_OKAY);
    wr(SCO_OFF_EN_DRV, {20'h0, drv}, SCO_RESP_OKAY);
    wr(SCO_OFF_EN_MODE, 32'h0000_0fff, SCO_RESP_OKAY);
    wr(SCO_OFF_EN_GPO, {20'h0, g}, SCO_RESP_OKAY);
    repeat (3) @(posedge clk);
    lv = g ~^ pol;
    ck(soe, 12'(drv | ~lv), "gpo oe");
    ck(so, 12'(drv & lv), "gpo level");
    wr(SCO_OFF_EN_MODE, 32'h0, SCO_RESP_OKAY);
    wr(SCO_OFF_EN_REQ, {20'h0, rq}, SCO_RESP_OKAY);
    repeat (3) @(posedge clk);
    lv = (rq & pol) | (~rq & ~pol);
    ck(soe, 12'(drv | ~lv), "req oe");
    ck(so, 12'(drv & lv), "req level");
  endtask
  task automatic t_pwm;
    int i, lo = 0;
    wr(SCO_OFF_PWM_CTL, 32'h0, SCO_RESP_OKAY);
    repeat (3) @(posedge clk);
    ck(poe, 8'h00, "pwm float");
    wr(SCO_OFF_DUTY0, 32'h0000_00ff, SCO_RESP_OKAY);
    wr(SCO_OFF_PWM_CTL, 32'h0002_0201, SCO_RESP_OKAY);
    repeat (3) @(posedge clk);
    for (i = 0; i < 300; i++) begin
      @(posedge clk);
      if (po[0] !== 1'b1 || poe[0] !== 1'b1) lo++;
    end
    ck(lo, 32'h0, "full duty lows");
    ck({po[1], poe[1]}, 2'h3, "pwm gpo");
    ck(poe[7:2], 6'h00, "unused float");
    wr(SCO_OFF_PWM_CTL, 32'h0002_0200, SCO_RESP_OKAY);
    repeat (3) @(posedge clk);
    ck(poe[0], 1'b0, "pwm disable float");
  endtask
  task automatic t_rerun;
    cf <= 12'h004;
    repeat (3) @(posedge clk);
    ck(foe, 3'h5, "fault before reset");
    rst <= 1;
    repeat (2) @(posedge clk);
    ck(foe, 3'h0, "lines in reset");
    rst <= 0;
    rcd <= 0;
    mon <= 0;
    cf <= 12'h000;
    repeat (3) @(posedge clk);
    ck({soe, poe, foe}, 32'h0, "oe after reset");
    rcd <= 1;
    repeat (3) @(posedge clk);
    ck(foe, 3'h7, "hold after reset");
  endtask
  initial begin
    t_reset;
    $display("test reset done");
    t_phase;
    $display("test phase done");
    t_flt;
    $display("test fault drive done");
    t_shut;
    $display("test shutdown done");
    t_psen;
    $display("test supply enable done");
    t_pwm;
    $display("test margin done");
    t_rerun;
    $display("test reset rerun done");
    test_done;
  end
endmodule
`default_nettype wire
